// ==== branch_cond_eval.sv ====
// Condition evaluation for the conditional short jumps and the count-zero jump
`timescale 1ns/100ps
module branch_cond_eval
  import branch_pkg::*;
(
  input wire logic [7:0] i_opcode,
  input wire flags_t i_flags,
  input wire logic [15:0] i_count,
  output logic o_is_cond,
  output logic o_cond_met
);

  logic sgn_ne_ovf;
  logic base_cond;
  logic jcc_met;
  logic is_jcc;
  logic is_cntz;

  assign sgn_ne_ovf = i_flags.sign ^ i_flags.overflow;

  // Odd opcodes are the negated sense of the even one below them
  always_comb begin
    case (i_opcode[3:1])
      3'h0: base_cond = i_flags.overflow;
      3'h1: base_cond = i_flags.carry;
      3'h2: base_cond = i_flags.zero;
      3'h3: base_cond = i_flags.carry | i_flags.zero;
      3'h4: base_cond = i_flags.sign;
      3'h5: base_cond = i_flags.parity;
      3'h6: base_cond = sgn_ne_ovf;
      3'h7: base_cond = i_flags.zero | sgn_ne_ovf;
      default: base_cond = 1'b0;
    endcase
  end

  assign jcc_met = base_cond ^ i_opcode[0];
  assign is_jcc = (i_opcode[7:4] == OP_JCC_HI);
  assign is_cntz = (i_opcode == OP_IF_COUNT_ZERO);
  assign o_is_cond = is_jcc | is_cntz;
  // Count-zero form looks only at the count, never the flags
  assign o_cond_met = is_cntz ? (i_count == 16'h0000) : (is_jcc & jcc_met);

endmodule

// ==== branch_condition_decode.sv ====
// Branch decode, target and fault generation with an AXI4-Lite status slave
//
// Chosen here: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
module branch_condition_decode
  import branch_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_req_valid,
  input wire jump_req_t i_req,
  output logic o_res_valid,
  output jump_res_t o_res,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp
);

  generate
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
      $error("CNT_W must lie in 1..32");
    end
  endgenerate
  function automatic logic [7:0] far_clocks(input far_kind_t kind, input logic prot,
                                            input logic mem, input logic [7:0] code_real,
                                            input logic [7:0] code_prot);
    logic [7:0] c;
    c = code_real;
    if (prot) begin
      case (kind)
        FAR_CODE: c = code_prot;
        FAR_CALL_GATE: c = mem ? CLK_GATE_MEM : CLK_GATE_IMM;
        FAR_TSS: c = mem ? CLK_TSS_MEM : CLK_TSS_IMM;
        FAR_TASK_GATE: c = mem ? CLK_TGATE_MEM : CLK_TGATE_IMM;
        default: c = code_prot;
      endcase
    end
    return c;
  endfunction

  // Control and status registers
  logic prot_mode_ff;
  logic sticky_gp_ff;
  logic sticky_ud_ff;
  logic [15:0] last_target_ff;
  logic [7:0] last_clocks_ff;
  logic last_redir_ff;
  logic last_cond_ff;
  logic [CNT_W-1:0] taken_count_ff;
  logic res_valid_ff;
  jump_res_t res_ff;

  // Decode of the incoming request
  logic is_cond;
  logic cond_met;
  logic is_cntz;
  logic is_short;
  logic is_near;
  logic is_far_imm;
  logic is_near_ind;
  logic is_far_ind;
  logic is_far;
  logic byte_disp;
  logic rel_form;
  logic known;
  logic taken;
  logic [15:0] disp_eff;
  logic [15:0] rel_target;
  logic [15:0] target;
  logic gp_fault;
  logic ud_fault;
  logic redirect;
  logic task_switch;
  logic [7:0] base_clocks;
  logic [7:0] total_clocks;
  logic accept;
  jump_res_t nxt_res;

  branch_cond_eval u_cond (
    .i_opcode(i_req.opcode),
    .i_flags(i_req.flags),
    .i_count(i_req.count),
    .o_is_cond(is_cond),
    .o_cond_met(cond_met)
  );

  assign is_cntz = (i_req.opcode == OP_IF_COUNT_ZERO);
  assign is_short = (i_req.opcode == OP_SHORT_JUMP);
  assign is_near = (i_req.opcode == OP_NEAR_JUMP);
  assign is_far_imm = (i_req.opcode == OP_FAR_IMM);
  assign is_near_ind = (i_req.opcode == OP_GROUP_FF) && (i_req.reg_field == REG_NEAR_IND);
  assign is_far_ind = (i_req.opcode == OP_GROUP_FF) && (i_req.reg_field == REG_FAR_IND);
  assign is_far = is_far_imm | is_far_ind;
  assign byte_disp = is_cond | is_short;
  assign rel_form = byte_disp | is_near;
  assign known = rel_form | is_near_ind | is_far;
  assign taken = is_cond ? cond_met : known;

  assign disp_eff = byte_disp ? {{8{i_req.disp[7]}}, i_req.disp[7:0]} : i_req.disp;
  assign rel_target = 16'(i_req.next_ip + disp_eff);
  assign target = rel_form ? rel_target : i_req.abs_offset;

  // Only near targets are limit-checked here; far targets get full checks elsewhere
  assign gp_fault = prot_mode_ff & taken & (rel_form | is_near_ind) &
                    (target > i_req.cs_limit);
  // A far indirect jump needs a memory pointer
  assign ud_fault = is_far_ind & ~i_req.mem_operand;
  assign redirect = taken & ~gp_fault & ~ud_fault;
  assign task_switch = is_far & prot_mode_ff &
                       ((i_req.far_kind == FAR_TSS) || (i_req.far_kind == FAR_TASK_GATE));

  assign base_clocks =
    is_cntz ? (taken ? CLK_CNTZ_TAKEN : CLK_CNTZ_NOJ) :
    is_cond ? (taken ? CLK_JCC_TAKEN : CLK_JCC_NOJ) :
    (is_short | is_near) ? CLK_REL_BRANCH :
    is_near_ind ? (i_req.mem_operand ? CLK_NEAR_IND_MEM : CLK_NEAR_IND_REG) :
    is_far_imm ? far_clocks(i_req.far_kind, prot_mode_ff, 1'b0,
                            CLK_FAR_IMM_REAL, CLK_FAR_IMM_PROT) :
    far_clocks(i_req.far_kind, prot_mode_ff, 1'b1,
               CLK_FAR_IND_REAL, CLK_FAR_IND_PROT);
  // Next-instruction bytes are charged whenever the branch is taken, even when a fault blocks the redirect
  assign total_clocks = 8'(base_clocks + (taken ? {4'h0, i_req.next_len} : 8'h00));

  always_comb begin
    nxt_res = '0;
    nxt_res.cond_met = taken;
    nxt_res.redirect = redirect;
    nxt_res.load_cs = redirect & is_far;
    nxt_res.flags_kept = ~(redirect & task_switch);
    nxt_res.gp_fault = gp_fault;
    nxt_res.ud_fault = ud_fault;
    nxt_res.fault_code = GP_ERR_CODE;
    nxt_res.new_ip = redirect ? target : i_req.next_ip;
    nxt_res.clocks = total_clocks;
  end

  // Unknown opcodes are not ours and produce no result
  assign accept = i_req_valid & known;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      res_valid_ff <= 1'b0;
      res_ff <= '0;
    end else begin
      res_valid_ff <= accept;
      if (accept) begin
        res_ff <= nxt_res;
      end
    end
  end
  assign o_res_valid = res_valid_ff;
  assign o_res = res_ff;

  // AXI4-Lite write path: address and data may arrive in either order
  logic aw_held_ff;
  logic w_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic do_write;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mapped;
  logic clr_gp;
  logic clr_ud;

  assign o_awready = ~aw_held_ff & ~bvalid_ff;
  assign o_wready = ~w_held_ff & ~bvalid_ff;
  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_ctrl = do_write && (awaddr_ff == REG_CTRL) && wstrb_ff[0];
  assign wr_status = do_write && (awaddr_ff == REG_STATUS) && wstrb_ff[0];
  assign wr_mapped = (awaddr_ff == REG_CTRL) || (awaddr_ff == REG_STATUS);
  assign clr_gp = wr_status & wdata_ff[ST_GP_BIT];
  assign clr_ud = wr_status & wdata_ff[ST_UD_BIT];

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
    end else if (i_awvalid && o_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= i_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      w_held_ff <= 1'b0;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (i_wvalid && o_wready) begin
      w_held_ff <= 1'b1;
      wdata_ff <= i_wdata;
      wstrb_ff <= i_wstrb;
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (i_bready) begin
      bvalid_ff <= 1'b0;
    end
  end
  assign o_bvalid = bvalid_ff;
  assign o_bresp = bresp_ff;

  // Register state; a fault in the clearing cycle stays set
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      prot_mode_ff <= CTRL_RESET;
      sticky_gp_ff <= 1'b0;
      sticky_ud_ff <= 1'b0;
      last_target_ff <= '0;
      last_clocks_ff <= '0;
      last_redir_ff <= 1'b0;
      last_cond_ff <= 1'b0;
      taken_count_ff <= '0;
    end else begin
      if (wr_ctrl) begin
        prot_mode_ff <= wdata_ff[CTRL_PROT_BIT];
      end
      sticky_gp_ff <= (accept & gp_fault) | (sticky_gp_ff & ~clr_gp);
      sticky_ud_ff <= (accept & ud_fault) | (sticky_ud_ff & ~clr_ud);
      if (accept) begin
        last_target_ff <= nxt_res.new_ip;
        last_clocks_ff <= nxt_res.clocks;
        last_redir_ff <= redirect;
        last_cond_ff <= taken;
      end
      if (accept && redirect) begin
        taken_count_ff <= CNT_W'(taken_count_ff + 1'b1);
      end
    end
  end

  // AXI4-Lite read path, one outstanding read
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic rd_mapped;
  logic [31:0] rd_word;
  logic [31:0] status_word;
  logic [31:0] count_word;

  assign status_word = {28'h0000000, last_cond_ff, last_redir_ff, sticky_ud_ff, sticky_gp_ff};
  assign count_word = 32'(taken_count_ff);
  assign rd_mapped = (i_araddr == REG_CTRL) || (i_araddr == REG_STATUS) ||
                     (i_araddr == REG_LAST_TARGET) || (i_araddr == REG_LAST_CLOCKS) ||
                     (i_araddr == REG_TAKEN_COUNT);
  assign rd_word =
    (i_araddr == REG_CTRL) ? {31'h00000000, prot_mode_ff} :
    (i_araddr == REG_STATUS) ? status_word :
    (i_araddr == REG_LAST_TARGET) ? {16'h0000, last_target_ff} :
    (i_araddr == REG_LAST_CLOCKS) ? {24'h000000, last_clocks_ff} :
    (i_araddr == REG_TAKEN_COUNT) ? count_word : 32'h00000000;
  assign o_arready = ~rvalid_ff;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_word;
      rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (i_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign o_rvalid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_rresp = rresp_ff;
  // Checks
  above_cond_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_req_valid && i_req.opcode == OP_IF_ABOVE
    |=> o_res_valid && o_res.cond_met == !($past(i_req.flags.carry) || $past(i_req.flags.zero)))
    else $error("above condition wrong");
  no_carry_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_req_valid && i_req.opcode == OP_IF_NO_CARRY
    |=> o_res.cond_met == !$past(i_req.flags.carry))
    else $error("no-carry condition wrong");
  zero_cond_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_req_valid && i_req.opcode == OP_IF_ZERO_RESULT
    |=> o_res.cond_met == $past(i_req.flags.zero))
    else $error("zero condition wrong");
  signed_le_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_req_valid && i_req.opcode == OP_IF_SIGNED_LE
    |=> o_res.cond_met == ($past(i_req.flags.zero) ||
                           ($past(i_req.flags.sign) != $past(i_req.flags.overflow))))
    else $error("signed not-greater condition wrong");
  count_zero_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_req_valid && i_req.opcode == OP_IF_COUNT_ZERO
    |=> o_res.cond_met == ($past(i_req.count) == 16'h0000))
    else $error("count-zero condition wrong");
  short_target_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_req_valid && i_req.opcode == OP_SHORT_JUMP && !gp_fault
    |=> o_res.redirect && o_res.new_ip ==
        16'($past(i_req.next_ip) + {{8{$past(i_req.disp[7])}}, $past(i_req.disp[7:0])}))
    else $error("short target wrong");
  untaken_clocks_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_req_valid && i_req.opcode[7:4] == OP_JCC_HI && !cond_met
    |=> !o_res.redirect && o_res.clocks == CLK_JCC_NOJ && o_res.new_ip == $past(i_req.next_ip))
    else $error("fall-through result wrong");
  near_limit_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_req_valid && prot_mode_ff && i_req.opcode == OP_NEAR_JUMP && rel_target > i_req.cs_limit
    |=> o_res.gp_fault && !o_res.redirect && o_res.fault_code == GP_ERR_CODE ##1 sticky_gp_ff)
    else $error("limit fault missing");
  far_imm_clocks_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_req_valid && is_far_imm && i_req.far_kind == FAR_CODE
    |=> o_res.clocks == ($past(prot_mode_ff) ? CLK_FAR_IMM_PROT : CLK_FAR_IMM_REAL) +
                        {4'h0, $past(i_req.next_len)})
    else $error("far immediate clocks wrong");
  flags_kept_a: assert property (@(posedge i_core_clk) disable iff (i_reset)
    i_req_valid && known && !task_switch |=> o_res.flags_kept)
    else $error("flags not kept");

endmodule

// ==== branch_condition_decode_tb.sv ====
// Self-checking bench: random jump stream with scoreboard, register bus checks
`timescale 1ns/100ps
module branch_condition_decode_tb;
  import branch_pkg::*;
  typedef struct packed {
    jump_res_t exp;
    jump_res_t mask;
    logic [31:0] cyc;
  } note_t;
  localparam int LIMIT = 6000;
  localparam logic [7:0] IMM_CLK [4] = '{CLK_FAR_IMM_PROT, CLK_GATE_IMM, CLK_TSS_IMM, CLK_TGATE_IMM};
  localparam logic [7:0] MEM_CLK [4] = '{CLK_FAR_IND_PROT, CLK_GATE_MEM, CLK_TSS_MEM, CLK_TGATE_MEM};
  localparam logic [10:0] OTHER [8] = '{{OP_IF_COUNT_ZERO, 3'h0}, {OP_SHORT_JUMP, 3'h0},
    {OP_NEAR_JUMP, 3'h0}, {OP_FAR_IMM, 3'h0}, {OP_GROUP_FF, REG_NEAR_IND},
    {OP_GROUP_FF, REG_FAR_IND}, {8'h90, 3'h0}, {OP_GROUP_FF, 3'h3}};
  logic i_core_clk, i_reset, req_valid, awvalid, wvalid, bready, arvalid, rready;
  logic o_res_valid, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic pm, gp_seen, ud_seen;
  logic [7:0] awaddr, araddr;
  logic [3:0] wstrb;
  logic [1:0] o_bresp, o_rresp;
  logic [15:0] model_ip;
  logic [31:0] wdata, o_rdata, seed, cyc, bad_count, checked, taken;
  jump_req_t req, dq;
  jump_res_t o_res, last;
  note_t notes[$];
  note_t n;

  branch_condition_decode i_branch_condition_decode (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_req_valid(req_valid), .i_req(req), .o_res_valid(o_res_valid), .o_res(o_res),
    .i_awvalid(awvalid), .o_awready(o_awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(o_wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(o_bvalid),
    .i_bready(bready), .o_bresp(o_bresp), .i_arvalid(arvalid), .o_arready(o_arready),
    .i_araddr(araddr), .o_rvalid(o_rvalid), .i_rready(rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp));
  datapath_model i_datapath_model (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_res_valid(o_res_valid), .i_res(o_res), .o_ip(model_ip));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  function automatic jump_res_t ref_res(input jump_req_t q, input logic p);
    jump_res_t r;
    logic [15:0] tgt;
    logic c, near, far;
    logic [7:0] base;
    logic [1:0] k;
    r = '0;
    c = 1'b1;
    near = 1'b1;
    far = 1'b0;
    k = q.far_kind;
    base = CLK_REL_BRANCH;
    tgt = q.next_ip + {{8{q.disp[7]}}, q.disp[7:0]};
    if (q.opcode[7:4] == OP_JCC_HI) begin
      case (q.opcode[3:1])
        3'h0: c = q.flags.overflow;
        3'h1: c = q.flags.carry;
        3'h2: c = q.flags.zero;
        3'h3: c = q.flags.carry | q.flags.zero;
        3'h4: c = q.flags.sign;
        3'h5: c = q.flags.parity;
        3'h6: c = q.flags.sign ^ q.flags.overflow;
        default: c = q.flags.zero | (q.flags.sign ^ q.flags.overflow);
      endcase
      c = c ^ q.opcode[0];
    end else if (q.opcode == OP_IF_COUNT_ZERO) begin
      c = q.count == 16'h0000;
      base = CLK_CNTZ_TAKEN;
    end else if (q.opcode == OP_NEAR_JUMP) begin
      tgt = q.next_ip + q.disp;
    end else if (q.opcode == OP_GROUP_FF && q.reg_field == REG_NEAR_IND) begin
      tgt = q.abs_offset;
      base = q.mem_operand ? CLK_NEAR_IND_MEM : CLK_NEAR_IND_REG;
    end else if (q.opcode == OP_FAR_IMM || q.opcode == OP_GROUP_FF) begin
      near = 1'b0;
      far = 1'b1;
      tgt = q.abs_offset;
      r.ud_fault = q.opcode == OP_GROUP_FF && !q.mem_operand;
      if (q.opcode == OP_FAR_IMM) begin
        base = p ? IMM_CLK[k] : CLK_FAR_IMM_REAL;
      end else begin
        base = p ? MEM_CLK[k] : CLK_FAR_IND_REAL;
      end
    end
    r.cond_met = c;
    r.clocks = c ? base + 8'(q.next_len) :
      (q.opcode == OP_IF_COUNT_ZERO ? CLK_CNTZ_NOJ : CLK_JCC_NOJ);
    r.gp_fault = p && near && c && tgt > q.cs_limit;
    r.fault_code = GP_ERR_CODE;
    r.redirect = c && !r.gp_fault && !r.ud_fault;
    r.load_cs = far && r.redirect;
    r.flags_kept = !(p && far && k[1]);
    r.new_ip = r.redirect ? tgt : q.next_ip;
    return r;
  endfunction

  function automatic jump_req_t rand_req();
    jump_req_t q;
    logic [4:0] idx;
    logic [127:0] raw;
    raw = {rnd(), rnd(), rnd(), rnd()};
    q = raw[$bits(jump_req_t)-1:0];
    idx = 5'(rnd() % 32'h18);
    if (idx < 5'h10) begin
      q.opcode = 8'h70 + 8'(idx);
    end else begin
      {q.opcode, q.reg_field} = OTHER[idx - 5'h10];
    end
    if (q.abs_offset[1:0] == 2'h0) begin
      q.count = 16'h0000;
    end
    return q;
  endfunction

  // Unknown opcodes are sent too but leave no note, so a stray result is caught
  task automatic send(input jump_req_t q, input logic v);
    note_t e;
    logic ok;
    ok = v && (q.opcode[7:4] == OP_JCC_HI || q.opcode inside {OP_IF_COUNT_ZERO, OP_SHORT_JUMP,
      OP_NEAR_JUMP, OP_FAR_IMM} || (q.opcode == OP_GROUP_FF && q.reg_field inside
      {REG_NEAR_IND, REG_FAR_IND}));
    req_valid <= v;
    req <= q;
    if (ok) begin
      e.exp = ref_res(q, pm);
      e.mask = '1;
      if (e.exp.ud_fault) begin
        e.mask.clocks = 8'h00;
        e.mask.cond_met = 1'b0;
        e.mask.flags_kept = 1'b0;
      end
      e.cyc = cyc + 32'h1;
      notes.push_back(e);
      taken += 32'(e.exp.redirect);
      gp_seen |= e.exp.gp_fault;
      ud_seen |= e.exp.ud_fault;
      last = e.exp;
    end
  endtask

  task automatic stream(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      send(rand_req(), rnd() % 32'h8 != 32'h0);
      @(posedge i_core_clk);
    end
    req_valid <= 1'b0;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_busy, w_busy;
    aw_busy = 1'b1;
    w_busy = 1'b1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    bready <= 1'b1;
    while (aw_busy || w_busy) begin
      @(posedge i_core_clk);
      if (aw_busy && o_awready === 1'b1) begin
        aw_busy = 1'b0;
        awvalid <= 1'b0;
      end
      if (w_busy && o_wready === 1'b1) begin
        w_busy = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge i_core_clk); while (o_bvalid !== 1'b1);
    check(64'(o_bresp), 64'(er));
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                          input logic [1:0] er);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge i_core_clk); while (o_arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge i_core_clk); while (o_rvalid !== 1'b1);
    check(64'(o_rdata & m), 64'(d));
    check(64'(o_rresp), 64'(er));
    rready <= 1'b0;
    // Let an edge pass so a following read does not reassign rready in this step
    @(posedge i_core_clk);
  endtask

  always @(negedge i_core_clk) begin
    if (o_res_valid === 1'b1) begin
      if (notes.size() == 0) begin
        check(64'h1, 64'h0);
      end else begin
        n = notes.pop_front();
        check(64'(o_res & n.mask), 64'(n.exp & n.mask));
        check(64'(cyc), 64'(n.cyc));
      end
    end
    cyc <= cyc + 32'h1;
    if (cyc > LIMIT) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  initial begin
    {i_reset, req_valid, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
    {pm, gp_seen, ud_seen, req, awaddr, araddr, wdata, wstrb, last} = '0;
    {cyc, bad_count, checked, taken} = '0;
    seed = 32'h0000002F;
    repeat (5) @(posedge i_core_clk);
    i_reset <= 1'b0;
    @(posedge i_core_clk);
    axi_read(REG_CTRL, 32'h0, 32'hFFFFFFFF, RESP_OKAY);
    stream(150);
    axi_write(REG_CTRL, 32'h1, RESP_OKAY);
    pm = 1'b1;
    axi_read(REG_CTRL, 32'h1, 32'hFFFFFFFF, RESP_OKAY);
    stream(250);
    @(posedge i_core_clk);
    dq = '0;
    dq.opcode = OP_SHORT_JUMP;
    dq.disp = 16'h0080;
    dq.next_ip = 16'h1000;
    dq.cs_limit = 16'hFFFF;
    dq.next_len = 4'h3;
    send(dq, 1'b1);
    @(posedge i_core_clk);
    req_valid <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    check(64'(model_ip), 64'h0F80);
    check(64'(notes.size()), 64'h0);
    axi_read(REG_TAKEN_COUNT, taken & 32'hFFFF, 32'hFFFF, RESP_OKAY);
    axi_read(REG_STATUS, {28'h0, last.cond_met, last.redirect, ud_seen, gp_seen}, 32'hF, RESP_OKAY);
    axi_read(REG_LAST_TARGET, 32'(last.new_ip), 32'hFFFF, RESP_OKAY);
    axi_read(REG_LAST_CLOCKS, 32'(last.clocks), 32'hFF, RESP_OKAY);
    axi_write(REG_STATUS, 32'h3, RESP_OKAY);
    axi_read(REG_STATUS, 32'h0, 32'h3, RESP_OKAY);
    axi_read(8'h40, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    axi_write(8'h40, 32'h1, RESP_SLVERR);
    print_verdict();
  end
endmodule

// ==== branch_pkg.sv ====
// Shared types and constants for the branch decoder and its register slave
package branch_pkg;

  // Opcodes of the branch forms handled here
  localparam logic [3:0] OP_JCC_HI = 4'h7;
  localparam logic [7:0] OP_IF_NO_CARRY = 8'h73;
  localparam logic [7:0] OP_IF_ABOVE = 8'h77;
  localparam logic [7:0] OP_IF_ZERO_RESULT = 8'h74;
  localparam logic [7:0] OP_IF_SIGNED_LE = 8'h7E;
  localparam logic [7:0] OP_IF_COUNT_ZERO = 8'hE3;
  localparam logic [7:0] OP_SHORT_JUMP = 8'hEB;
  localparam logic [7:0] OP_NEAR_JUMP = 8'hE9;
  localparam logic [7:0] OP_FAR_IMM = 8'hEA;
  localparam logic [7:0] OP_GROUP_FF = 8'hFF;
  localparam logic [2:0] REG_NEAR_IND = 3'h4;
  localparam logic [2:0] REG_FAR_IND = 3'h5;

  // Execution clock counts per form
  localparam logic [7:0] CLK_JCC_TAKEN = 8'h07;
  localparam logic [7:0] CLK_JCC_NOJ = 8'h03;
  localparam logic [7:0] CLK_CNTZ_TAKEN = 8'h08;
  localparam logic [7:0] CLK_CNTZ_NOJ = 8'h04;
  localparam logic [7:0] CLK_REL_BRANCH = 8'h07;
  localparam logic [7:0] CLK_NEAR_IND_REG = 8'h07;
  localparam logic [7:0] CLK_NEAR_IND_MEM = 8'h0B;
  localparam logic [7:0] CLK_FAR_IMM_REAL = 8'h0B;
  localparam logic [7:0] CLK_FAR_IMM_PROT = 8'h17;
  localparam logic [7:0] CLK_FAR_IND_REAL = 8'h0F;
  localparam logic [7:0] CLK_FAR_IND_PROT = 8'h1A;
  localparam logic [7:0] CLK_GATE_IMM = 8'h26;
  localparam logic [7:0] CLK_GATE_MEM = 8'h29;
  localparam logic [7:0] CLK_TSS_IMM = 8'hAF;
  localparam logic [7:0] CLK_TSS_MEM = 8'hB2;
  localparam logic [7:0] CLK_TGATE_IMM = 8'hB4;
  localparam logic [7:0] CLK_TGATE_MEM = 8'hB7;

  localparam logic [15:0] GP_ERR_CODE = 16'h0000;

  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LAST_TARGET = 8'h08;
  localparam logic [7:0] REG_LAST_CLOCKS = 8'h0C;
  localparam logic [7:0] REG_TAKEN_COUNT = 8'h10;
  localparam int CTRL_PROT_BIT = 0;
  localparam int ST_GP_BIT = 0;
  localparam int ST_UD_BIT = 1;
  localparam int ST_REDIR_BIT = 2;
  localparam int ST_COND_BIT = 3;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {FAR_CODE, FAR_CALL_GATE, FAR_TSS, FAR_TASK_GATE} far_kind_t;

  typedef struct packed {
    logic carry;
    logic parity;
    logic zero;
    logic sign;
    logic overflow;
  } flags_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [2:0] reg_field;
    logic mem_operand;
    far_kind_t far_kind;
    logic [15:0] disp;
    logic [15:0] next_ip;
    logic [15:0] abs_offset;
    logic [15:0] count;
    logic [15:0] cs_limit;
    logic [3:0] next_len;
    flags_t flags;
  } jump_req_t;

  typedef struct packed {
    logic cond_met;
    logic redirect;
    logic load_cs;
    logic flags_kept;
    logic gp_fault;
    logic ud_fault;
    logic [15:0] fault_code;
    logic [15:0] new_ip;
    logic [7:0] clocks;
  } jump_res_t;

endpackage

// ==== datapath_model.sv ====
// Far-side model: instruction pointer register fed by decoder results
`timescale 1ns/100ps
module datapath_model
  import branch_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_res_valid,
  input wire jump_res_t i_res,
  output logic [15:0] o_ip
);
  logic [15:0] ip_ff;
  assign o_ip = ip_ff;
  // Follows every result, taken or not, as fetch would
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ip_ff <= 16'h0000;
    end else if (i_res_valid) begin
      ip_ff <= i_res.new_ip;
    end
  end
endmodule
